// ==== hdl/rpsm_top.sv ====
// Remappable pin select map: select registers on Wishbone, input and output routing
`timescale 1ns/1ps
`include "rpsm_defines.svh"

// Overview of operation
// - PWM sync input 1 source chosen by upper byte; lower byte unused.
// - Select code zero ties the peripheral input low.
// - Select code one connects comparator 1 output.
// - Code 181 selects input pin 181; intermediate codes select that pin.
// - Dead-time compensation input 1 source chosen by upper byte of its register.
// - Dead-time compensation input 3 source in upper byte of shared register.
// - Dead-time compensation input 2 source in lower byte of shared register.
// - Sensor link input 1 source chosen by upper byte of its register.
// - Sensor link input 2 source in lower byte; upper byte unused.
// - Unimplemented bits ignore writes and read zero.
// - Each output register holds two 6-bit codes, bits 13:8 and 5:0.
// - Output register bits 15:14 and 7:6 read zero.
// - Implemented bits read/write and clear to zero at reset.
// - Output pairs upper/lower: 35/20 37/36 39/38 41/40 43/42 49/48 55/54.
// - Registers for pins 48, 49, 54, 55 exist only on large variants.
module rpsm_top #(
  parameter int NUM_IN_PINS   = 182,
  parameter int NUM_FUNC      = 64,
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         resetn_i,
  // Wishbone slave
  input  wire rpsm_pkg::rpsm_wb_req_t       wb_req_i,
  output rpsm_pkg::rpsm_wb_rsp_t            wb_rsp_o,
  // Input sources from pins and comparator
  input  wire logic [NUM_IN_PINS-1:0]       remap_pin_in_i,
  input  wire logic                         comparator_one_output_i,
  // Routed peripheral inputs
  output rpsm_pkg::rpsm_in_route_t          in_route_o,
  // Output sources from peripherals and port logic
  input  wire logic [NUM_FUNC-1:0]          periph_func_i,
  input  wire logic [`RPSM_OUT_PINS-1:0]    port_data_i,
  input  wire logic [`RPSM_OUT_PINS-1:0]    port_oe_i,
  // Remappable output pins, pin order 20,35..43,48,49,54,55
  output logic      [`RPSM_OUT_PINS-1:0]    remap_pin_out_o,
  output logic      [`RPSM_OUT_PINS-1:0]    remap_pin_oe_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  initial begin
    if (NUM_IN_PINS < 2 || NUM_IN_PINS > 256) begin
      $error("rpsm_top: NUM_IN_PINS out of range");
    end
    if (NUM_FUNC < 2 || NUM_FUNC > 64) begin
      $error("rpsm_top: NUM_FUNC out of range");
    end
    if (`RPSM_OUT_PINS != 2 * `RPSM_OUT_REGS) begin
      $error("rpsm_top: output pins and registers do not pair up");
    end
  end

  localparam int SW = `RPSM_SEL_W;
  localparam int FW = `RPSM_FUNC_W;
  localparam int NP = `RPSM_OUT_PINS;
  localparam int NR = `RPSM_OUT_REGS;
  // Output registers 5 and 6 carry pins 48, 49, 54 and 55
  localparam int NR_PRESENT = LARGE_VARIANT ? NR : NR - 2;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        req_w;
  logic        wr_lo_w;
  logic        wr_hi_w;
  logic        ack_q;
  logic [31:0] rd_dat_q;
  logic [15:0] rd_view_w;
  logic        hit_w;

  // A request is taken once; ack drops in the cycle after it is given
  assign req_w   = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign wr_lo_w = req_w & wb_req_i.we & wb_req_i.sel[0];
  assign wr_hi_w = req_w & wb_req_i.we & wb_req_i.sel[1];

  // Per-field write strobes; sel[3:2] carry no register bits and are ignored
  logic wr_pwm_sync_w;
  logic wr_dt1_w;
  logic wr_dt3_w;
  logic wr_dt2_w;
  logic wr_sensor1_w;
  logic wr_sensor2_w;

  assign wr_pwm_sync_w = wr_hi_w && wb_req_i.adr == `RPSM_OFS_PWM_SYNC;
  assign wr_dt1_w      = wr_hi_w && wb_req_i.adr == `RPSM_OFS_DT1;
  assign wr_dt3_w      = wr_hi_w && wb_req_i.adr == `RPSM_OFS_DT23;
  assign wr_dt2_w      = wr_lo_w && wb_req_i.adr == `RPSM_OFS_DT23;
  assign wr_sensor1_w  = wr_hi_w && wb_req_i.adr == `RPSM_OFS_SENT1;
  assign wr_sensor2_w  = wr_lo_w && wb_req_i.adr == `RPSM_OFS_SENT2;

  // --------------------------------------------------------------------------
  // Input select fields
  // --------------------------------------------------------------------------
  // Each field sits in one byte lane and is written only through that lane
  logic [SW-1:0] pwm_sync_source_field_q;
  logic [SW-1:0] deadtime_comp1_source_field_q;
  logic [SW-1:0] deadtime_comp2_source_field_q;
  logic [SW-1:0] deadtime_comp3_source_field_q;
  logic [SW-1:0] sensor_link1_source_field_q;
  logic [SW-1:0] sensor_link2_source_field_q;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pwm_sync_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_pwm_sync_w) begin
      pwm_sync_source_field_q <= wb_req_i.dat[`RPSM_SEL_HI_LSB +: SW];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      deadtime_comp1_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_dt1_w) begin
      deadtime_comp1_source_field_q <= wb_req_i.dat[`RPSM_SEL_HI_LSB +: SW];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      deadtime_comp3_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_dt3_w) begin
      deadtime_comp3_source_field_q <= wb_req_i.dat[`RPSM_SEL_HI_LSB +: SW];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      deadtime_comp2_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_dt2_w) begin
      deadtime_comp2_source_field_q <= wb_req_i.dat[`RPSM_SEL_LO_LSB +: SW];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sensor_link1_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_sensor1_w) begin
      sensor_link1_source_field_q <= wb_req_i.dat[`RPSM_SEL_HI_LSB +: SW];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sensor_link2_source_field_q <= `RPSM_SEL_RST;
    end else if (wr_sensor2_w) begin
      sensor_link2_source_field_q <= wb_req_i.dat[`RPSM_SEL_LO_LSB +: SW];
    end
  end

  // --------------------------------------------------------------------------
  // Output function code fields
  // --------------------------------------------------------------------------
  // Entry 2r is the lower field of output register r, entry 2r+1 the upper
  logic [FW-1:0] func_code_q [NP];
  logic [7:0]    out_ofs_w   [NR];

  assign out_ofs_w[0] = `RPSM_OFS_OUT0;
  assign out_ofs_w[1] = `RPSM_OFS_OUT1;
  assign out_ofs_w[2] = `RPSM_OFS_OUT2;
  assign out_ofs_w[3] = `RPSM_OFS_OUT3;
  assign out_ofs_w[4] = `RPSM_OFS_OUT4;
  assign out_ofs_w[5] = `RPSM_OFS_OUT5;
  assign out_ofs_w[6] = `RPSM_OFS_OUT6;

  genvar gr;
  generate
    for (gr = 0; gr < NR; gr++) begin : g_out_reg
      if (gr < NR_PRESENT) begin : g_present
        always_ff @(posedge clk_sys_i) begin
          if (!resetn_i) begin
            func_code_q[2*gr] <= `RPSM_FUNC_RST;
          end else if (wr_lo_w && wb_req_i.adr == out_ofs_w[gr]) begin
            func_code_q[2*gr] <= wb_req_i.dat[`RPSM_FUNC_LO_LSB +: FW];
          end
        end
        always_ff @(posedge clk_sys_i) begin
          if (!resetn_i) begin
            func_code_q[2*gr+1] <= `RPSM_FUNC_RST;
          end else if (wr_hi_w && wb_req_i.adr == out_ofs_w[gr]) begin
            func_code_q[2*gr+1] <= wb_req_i.dat[`RPSM_FUNC_HI_LSB +: FW];
          end
        end
      end else begin : g_absent
        // Small variants have no storage here; the pins stay on port control
        // Driven from a process so the array never mixes assign and always_ff
        always_ff @(posedge clk_sys_i) begin
          func_code_q[2*gr]   <= `RPSM_FUNC_RST;
          func_code_q[2*gr+1] <= `RPSM_FUNC_RST;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read view
  // --------------------------------------------------------------------------
  // Decoded from the live address; the master holds it until ack
  always_comb begin
    rd_view_w = 16'h0000;
    hit_w     = 1'b1;
    case (wb_req_i.adr)
      `RPSM_OFS_PWM_SYNC: begin
        rd_view_w = {pwm_sync_source_field_q, 8'h00};
      end
      `RPSM_OFS_DT1: begin
        rd_view_w = {deadtime_comp1_source_field_q, 8'h00};
      end
      `RPSM_OFS_DT23: begin
        rd_view_w = {deadtime_comp3_source_field_q, deadtime_comp2_source_field_q};
      end
      `RPSM_OFS_SENT1: begin
        rd_view_w = {sensor_link1_source_field_q, 8'h00};
      end
      `RPSM_OFS_SENT2: begin
        rd_view_w = {8'h00, sensor_link2_source_field_q};
      end
      default: begin
        hit_w = 1'b0;
        for (int r = 0; r < NR; r++) begin
          if (wb_req_i.adr == out_ofs_w[r] && r < NR_PRESENT) begin
            rd_view_w = {2'b00, func_code_q[2*r+1], 2'b00, func_code_q[2*r]};
            hit_w     = 1'b1;
          end
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  // One wait state: ack follows the taking edge and falls one cycle later
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w;
    end
  end

  // Unmapped and absent offsets are still acknowledged and read as zero
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rd_dat_q <= 32'h0000_0000;
    end else if (req_w) begin
      rd_dat_q <= hit_w ? {16'h0000, rd_view_w} : 32'h0000_0000;
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rd_dat_q;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Pins and the comparator are asynchronous to the system clock
  // Reset clears both stages, the same level as a grounded source
  logic [NUM_IN_PINS-1:0] pin_meta_q;
  logic [NUM_IN_PINS-1:0] pin_sync_q;
  logic                   cmp_meta_q;
  logic                   cmp_sync_q;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= remap_pin_in_i;
      pin_sync_q <= pin_meta_q;
      cmp_meta_q <= comparator_one_output_i;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Input routing
  // --------------------------------------------------------------------------
  // Routing follows the fields combinationally; no update handshake
  logic [SW-1:0] in_sel_w   [6];
  logic [5:0]    in_route_w;

  assign in_sel_w[0] = pwm_sync_source_field_q;
  assign in_sel_w[1] = deadtime_comp1_source_field_q;
  assign in_sel_w[2] = deadtime_comp2_source_field_q;
  assign in_sel_w[3] = deadtime_comp3_source_field_q;
  assign in_sel_w[4] = sensor_link1_source_field_q;
  assign in_sel_w[5] = sensor_link2_source_field_q;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_in_mux
      // Code 0 ground, 1 comparator, 2..181 the numbered pin
      rpsm_in_mux #(
        .NUM_PINS (NUM_IN_PINS)
      ) u_in_mux (
        .sel_i   (in_sel_w[gi]),
        .cmp_i   (cmp_sync_q),
        .pin_i   (pin_sync_q),
        .route_o (in_route_w[gi])
      );
    end
  endgenerate

  assign in_route_o.pwm_sync     = in_route_w[0];
  assign in_route_o.dt_comp1     = in_route_w[1];
  assign in_route_o.dt_comp2     = in_route_w[2];
  assign in_route_o.dt_comp3     = in_route_w[3];
  assign in_route_o.sensor_link1 = in_route_w[4];
  assign in_route_o.sensor_link2 = in_route_w[5];

  // --------------------------------------------------------------------------
  // Output routing
  // --------------------------------------------------------------------------
  // Both variants keep all fourteen pins; absent registers leave code zero
  genvar go;
  generate
    for (go = 0; go < NP; go++) begin : g_out_mux
      // Function code zero hands the pin back to its port latch and direction
      rpsm_out_mux #(
        .NUM_FUNC (NUM_FUNC)
      ) u_out_mux (
        .code_i      (func_code_q[go]),
        .func_i      (periph_func_i),
        .port_data_i (port_data_i[go]),
        .port_oe_i   (port_oe_i[go]),
        .pin_o       (remap_pin_out_o[go]),
        .pin_oe_o    (remap_pin_oe_o[go])
      );
    end
  endgenerate

endmodule

// ==== hdl/rpsm_defines.svh ====
// Register offsets, field positions, reset values and select codes of the pin select map
`ifndef RPSM_DEFINES_SVH
`define RPSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------------
`define RPSM_OFS_PWM_SYNC   8'h00
`define RPSM_OFS_DT1        8'h04
`define RPSM_OFS_DT23       8'h08
`define RPSM_OFS_SENT1      8'h0c
`define RPSM_OFS_SENT2      8'h10
`define RPSM_OFS_OUT0       8'h20
`define RPSM_OFS_OUT1       8'h24
`define RPSM_OFS_OUT2       8'h28
`define RPSM_OFS_OUT3       8'h2c
`define RPSM_OFS_OUT4       8'h30
`define RPSM_OFS_OUT5       8'h34
`define RPSM_OFS_OUT6       8'h38

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define RPSM_SEL_W          8
`define RPSM_SEL_HI_LSB     8
`define RPSM_SEL_LO_LSB     0
`define RPSM_FUNC_W         6
`define RPSM_FUNC_HI_LSB    8
`define RPSM_FUNC_LO_LSB    0
`define RPSM_OUT_PINS       14
`define RPSM_OUT_REGS       7

// ----------------------------------------------------------------------------
// Reset values and special codes
// ----------------------------------------------------------------------------
`define RPSM_SEL_RST        8'h00
`define RPSM_FUNC_RST       6'h00
`define RPSM_SEL_VSS        8'h00
`define RPSM_SEL_COMPARATOR_ONE_OUTPUT       8'h01
`define RPSM_SEL_MAX        8'hb5
`define RPSM_FUNC_PORT      6'h00

`endif

// ==== hdl/rpsm_pkg.sv ====
// Types shared by the pin select map modules
package rpsm_pkg;

  // --------------------------------------------------------------------------
  // Wishbone carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rpsm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rpsm_wb_rsp_t;

  // --------------------------------------------------------------------------
  // Routed peripheral inputs
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pwm_sync;
    logic dt_comp1;
    logic dt_comp2;
    logic dt_comp3;
    logic sensor_link1;
    logic sensor_link2;
  } rpsm_in_route_t;

endpackage

// ==== hdl/rpsm_in_mux.sv ====
// Input select multiplexer: one peripheral input from ground, comparator or a pin
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_in_mux #(
  parameter int NUM_PINS = 182
) (
  // Select
  input  wire logic [`RPSM_SEL_W-1:0] sel_i,
  // Sources
  input  wire logic                   cmp_i,
  input  wire logic [NUM_PINS-1:0]    pin_i,
  // Routed input
  output logic                        route_o
);

  initial begin
    if (NUM_PINS < 2 || NUM_PINS > 256) begin
      $error("rpsm_in_mux: NUM_PINS out of range");
    end
  end

  always_comb begin
    if (sel_i == `RPSM_SEL_VSS) begin
      route_o = 1'b0;
    end else if (sel_i == `RPSM_SEL_COMPARATOR_ONE_OUTPUT) begin
      route_o = cmp_i;
    end else if (sel_i <= `RPSM_SEL_MAX && int'(sel_i) < NUM_PINS) begin
      route_o = pin_i[sel_i];
    end else begin
      // Codes above the top pin have no source and read as ground
      route_o = 1'b0;
    end
  end

endmodule

// ==== hdl/rpsm_out_mux.sv ====
// Output select multiplexer: one remappable pin from a peripheral function or its port
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_out_mux #(
  parameter int NUM_FUNC = 64
) (
  // Select
  input  wire logic [`RPSM_FUNC_W-1:0] code_i,
  // Sources
  input  wire logic [NUM_FUNC-1:0]     func_i,
  input  wire logic                    port_data_i,
  input  wire logic                    port_oe_i,
  // Pin drive
  output logic                         pin_o,
  output logic                         pin_oe_o
);

  initial begin
    if (NUM_FUNC < 2 || NUM_FUNC > 64) begin
      $error("rpsm_out_mux: NUM_FUNC out of range");
    end
  end

  always_comb begin
    if (code_i == `RPSM_FUNC_PORT) begin
      pin_o    = port_data_i;
      pin_oe_o = port_oe_i;
    end else if (int'(code_i) < NUM_FUNC) begin
      pin_o    = func_i[code_i];
      pin_oe_o = 1'b1;
    end else begin
      pin_o    = 1'b0;
      pin_oe_o = 1'b1;
    end
  end

endmodule

// ==== verif/rpsm_top_monitor.sv ====
// Port-level assertions for the remappable pin select map
`timescale 1ns/1ps
`include "rpsm_defines.svh"

module rpsm_top_monitor #(
  parameter int NUM_IN_PINS   = 182,
  parameter int NUM_FUNC      = 64,
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic                      clk_sys_i,
  input wire logic                      resetn_i,
  // Register bus
  input wire rpsm_pkg::rpsm_wb_req_t    wb_req_i,
  input wire rpsm_pkg::rpsm_wb_rsp_t    wb_rsp_o,
  // Input routing
  input wire logic [NUM_IN_PINS-1:0]    remap_pin_in_i,
  input wire logic                      comparator_one_output_i,
  input wire rpsm_pkg::rpsm_in_route_t  in_route_o,
  // Output routing
  input wire logic [NUM_FUNC-1:0]       periph_func_i,
  input wire logic [`RPSM_OUT_PINS-1:0] port_data_i,
  input wire logic [`RPSM_OUT_PINS-1:0] port_oe_i,
  input wire logic [`RPSM_OUT_PINS-1:0] remap_pin_out_o,
  input wire logic [`RPSM_OUT_PINS-1:0] remap_pin_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Address is still held by the master in the ack cycle
  logic       rd_ack;
  logic [7:0] adr;
  assign rd_ack = wb_rsp_o.ack && !wb_req_i.we;
  assign adr    = wb_req_i.adr;

  a_ack_one_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered next cycle");
  a_ack_has_cause: assert property (
    wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack))
    else $error("ack without a request");
  a_upper_half_zero: assert property (rd_ack |-> wb_rsp_o.dat[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_in_low_byte_zero: assert property (rd_ack && (adr == `RPSM_OFS_PWM_SYNC ||
    adr == `RPSM_OFS_DT1 || adr == `RPSM_OFS_SENT1) |-> wb_rsp_o.dat[7:0] == 8'h00)
    else $error("unused low byte not zero");
  a_sensor2_hi_zero: assert property (rd_ack && adr == `RPSM_OFS_SENT2
    |-> wb_rsp_o.dat[15:8] == 8'h00)
    else $error("unused high byte not zero");
  a_out_gaps_zero: assert property (rd_ack && adr inside {[8'h20:8'h38]}
    |-> (wb_rsp_o.dat & 32'h0000_c0c0) == 32'h0)
    else $error("output register gap bits not zero");
  a_unmapped_zero: assert property (rd_ack && !(adr inside {`RPSM_OFS_PWM_SYNC,
    `RPSM_OFS_DT1, `RPSM_OFS_DT23, `RPSM_OFS_SENT1, `RPSM_OFS_SENT2, `RPSM_OFS_OUT0,
    `RPSM_OFS_OUT1, `RPSM_OFS_OUT2, `RPSM_OFS_OUT3, `RPSM_OFS_OUT4, `RPSM_OFS_OUT5,
    `RPSM_OFS_OUT6}) |-> wb_rsp_o.dat == 32'h0)
    else $error("unmapped read not zero");
  a_reset_ground: assert property ($rose(resetn_i) |-> in_route_o == 6'h00)
    else $error("inputs not grounded after reset");
  a_reset_port_ctl: assert property ($rose(resetn_i) |->
    remap_pin_out_o == port_data_i && remap_pin_oe_o == port_oe_i)
    else $error("pins not under port control after reset");
endmodule

// ==== verif/rpsm_tb.sv ====
// Self-checking bench for the remappable pin select map
`timescale 1ns/1ps
`include "rpsm_defines.svh"

`define CHK(name, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); \
  end \
end

module testbench;
  // ----
  // Signals
  // ----
  logic                     clk_sys_i;
  logic                     resetn_i;
  rpsm_pkg::rpsm_wb_req_t   wb_req;
  rpsm_pkg::rpsm_wb_rsp_t   wb_rsp;
  rpsm_pkg::rpsm_wb_rsp_t   wb_rsp_s;
  rpsm_pkg::rpsm_in_route_t route;
  logic [181:0]             pin_in;
  logic                     cmp_in;
  logic [63:0]              func;
  logic [13:0]              port_data, port_oe, pin_out, pin_oe, pin_out_s;
  logic [31:0]              rd, rd_s;
  int                       errors, total_checks;
  logic [7:0]  reg_adr [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28,
                                8'h2c, 8'h30, 8'h34, 8'h38};
  logic [15:0] reg_mask[12] = '{16'hff00, 16'hff00, 16'hffff, 16'hff00, 16'h00ff, 16'h3f3f,
                                16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f, 16'h3f3f};
  logic [7:0]  in_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h10};
  int          in_lsb [6] = '{8, 8, 8, 0, 8, 0};
  int          in_bit [6] = '{5, 4, 2, 3, 1, 0};

  rpsm_top u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_req_i(wb_req),
    .wb_rsp_o(wb_rsp), .remap_pin_in_i(pin_in), .comparator_one_output_i(cmp_in),
    .in_route_o(route), .periph_func_i(func), .port_data_i(port_data), .port_oe_i(port_oe),
    .remap_pin_out_o(pin_out), .remap_pin_oe_o(pin_oe));

  // Small variant shares every input; only its answers and pins are compared
  rpsm_top #(.LARGE_VARIANT(1'b0)) u_dut_small (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp_s), .remap_pin_in_i(pin_in),
    .comparator_one_output_i(cmp_in), .in_route_o(), .periph_func_i(func),
    .port_data_i(port_data), .port_oe_i(port_oe), .remap_pin_out_o(pin_out_s),
    .remap_pin_oe_o());

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ----
  // Bus and helper tasks
  // ----
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    rd = wb_rsp.dat;
    rd_s = wb_rsp_s.dat;
    `CHK("ack", 1'b1, wb_rsp.ack)
    wb_req <= '0;
    @(posedge clk_sys_i);
  endtask

  task automatic do_reset;
    resetn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int r = 0; r < 12; r++) begin
      wb_xfer(1'b0, reg_adr[r], 4'hf, 32'h0);
      `CHK("reset_val", 32'h0, rd)
    end
    `CHK("reset_route", 6'h00, route)
    `CHK("reset_pins", port_data, pin_out)
  endtask

  task automatic t_regs;
    for (int r = 0; r < 12; r++) begin
      wb_xfer(1'b1, reg_adr[r], 4'hf, 32'hffff_ffff);
      wb_xfer(1'b0, reg_adr[r], 4'hf, 32'h0);
      `CHK("reg_rw", {16'h0, reg_mask[r]}, rd)
      `CHK("reg_small", r > 9 ? 32'h0 : {16'h0, reg_mask[r]}, rd_s)
      wb_xfer(1'b1, reg_adr[r], 4'h1, 32'h0);
      wb_xfer(1'b0, reg_adr[r], 4'hf, 32'h0);
      `CHK("reg_lane", {16'h0, reg_mask[r] & 16'hff00}, rd)
      wb_xfer(1'b1, reg_adr[r], 4'hf, 32'h0);
    end
    foreach (in_adr[k]) begin
      wb_xfer(1'b1, 8'h14 + 8'(k * 44), 4'hf, 32'hffff_ffff);
      wb_xfer(1'b0, 8'h14 + 8'(k * 44), 4'hf, 32'h0);
      `CHK("unmapped", 32'h0, rd)
    end
  endtask

  task automatic in_case(int k, logic [7:0] code, logic [181:0] pins, logic c, logic hit);
    pin_in <= pins;
    cmp_in <= c;
    wb_xfer(1'b1, in_adr[k], in_lsb[k] == 8 ? 4'h2 : 4'h1, 32'(code) << in_lsb[k]);
    repeat (3) @(posedge clk_sys_i);
    `CHK("in_route", hit ? 6'h01 << in_bit[k] : 6'h00, route)
  endtask

  task automatic t_in_route;
    for (int k = 0; k < 6; k++) begin
      in_case(k, `RPSM_SEL_MAX, 182'h1 << 181, 1'b0, 1'b1);
      in_case(k, `RPSM_SEL_COMPARATOR_ONE_OUTPUT, '0, 1'b1, 1'b1);
      in_case(k, 8'h23, 182'h1 << 35, 1'b0, 1'b1);
      in_case(k, 8'hb6, '1, 1'b1, 1'b0);
      in_case(k, `RPSM_SEL_VSS, '1, 1'b1, 1'b0);
    end
  endtask

  task automatic t_out;
    logic [5:0] code;
    logic [7:0] adr;
    for (int i = 0; i < 14; i++) begin
      code = 6'(i + 5);
      adr = 8'h20 + 8'(4 * (i / 2));
      func <= 64'h1 << code;
      port_data <= '0;
      port_oe <= '0;
      wb_xfer(1'b1, adr, i % 2 ? 4'h2 : 4'h1, 32'(code) << (i % 2 ? 8 : 0));
      `CHK("pin_out", 14'h1 << i, pin_out)
      `CHK("pin_oe", 14'h1 << i, pin_oe)
      `CHK("pin_small", i > 9 ? 14'h0 : 14'h1 << i, pin_out_s)
      port_data <= 14'h2aaa;
      port_oe <= 14'h1555;
      wb_xfer(1'b1, adr, 4'h3, 32'h0);
      `CHK("port_data", 14'h2aaa, pin_out)
      `CHK("port_oe", 14'h1555, pin_oe)
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    wb_req = '0;
    pin_in = '0;
    cmp_in = 1'b0;
    func = '0;
    port_data = '0;
    port_oe = '0;
    errors = 0;
    total_checks = 0;
    do_reset();
    t_reset();
    t_regs();
    t_in_route();
    t_out();
    wb_xfer(1'b1, 8'h08, 4'h3, 32'h0000_5a5a);
    do_reset();
    t_reset();
    stop_test();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    stop_test();
  end
endmodule

bind rpsm_top rpsm_top_monitor #(.NUM_IN_PINS(NUM_IN_PINS), .NUM_FUNC(NUM_FUNC),
  .LARGE_VARIANT(LARGE_VARIANT)) u_monitor (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .remap_pin_in_i(remap_pin_in_i),
  .comparator_one_output_i(comparator_one_output_i), .in_route_o(in_route_o),
  .periph_func_i(periph_func_i), .port_data_i(port_data_i), .port_oe_i(port_oe_i),
  .remap_pin_out_o(remap_pin_out_o), .remap_pin_oe_o(remap_pin_oe_o));
